/* File: hw/swdl_defines.vh */
// Constants for the single-wire debug link bit engine
`ifndef SWDL_DEFINES_VH
`define SWDL_DEFINES_VH

// ****************************************
// Bit timing, in debug-clock ticks
// ****************************************
`define SWDL_BIT_NOM 8'h10
`define SWDL_BIT_SAMPLE 8'h0A
`define SWDL_ONE_PULSE 8'h07
`define SWDL_ZERO_LOW 8'h0D
`define SWDL_TIMEOUT 10'h200

// ****************************************
// Rate probe timing
// ****************************************
`define SWDL_SYNC_DET 8'h80
`define SWDL_SYNC_GAP 8'h10
`define SWDL_SYNC_LOW 8'h80

// ****************************************
// Framing and command classes
// ****************************************
`define SWDL_BYTE_LAST 3'h7
`define SWDL_CMD_CLASS_BIT 7
`define SWDL_SEL_ALT 1'b1

// ****************************************
// Engine states
// ****************************************
`define SWDL_ST_IDLE 3'h0
`define SWDL_ST_HBIT 3'h1
`define SWDL_ST_TBIT 3'h2
`define SWDL_ST_SWAIT 3'h3
`define SWDL_ST_SGAP 3'h4
`define SWDL_ST_SLOW 3'h5
`define SWDL_ST_SPULSE 3'h6

`endif

/* File: hw/swdl_tick.v */
// Debug clock source selection as a tick enable
`timescale 1ns/1ps
`include "swdl_defines.vh"

module swdl_tick
(
  input wire clk,
  input wire rst,
  input wire ce,
  input wire clk_sel,
  input wire alt_tick,
  output wire tick
);
  reg tick_q;

  // One clock domain: the alternate source arrives as a tick, not a clock
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      tick_q <= 1'b0;
    else if (ce)
      tick_q <= (clk_sel == `SWDL_SEL_ALT) ? alt_tick : 1'b1;
  end

  assign tick = tick_q;
endmodule // swdl_tick

/* File: hw/swdl_fifo.v */
// Received byte FIFO with registered output stage
`timescale 1ns/1ps

module swdl_fifo
#(
  parameter W = 9,
  parameter DEPTH = 16,
  parameter AW = 4
)
(
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  localparam [AW:0] FULL_CNT = DEPTH;
  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg [AW:0] cnt_d;
  reg in_ready_q;
  reg out_valid_q;
  reg [W-1:0] out_data_q;
  wire push;
  wire load;

  assign push = in_valid & in_ready_q;
  assign load = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);

  always @*
  begin
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_entry
      always @(posedge clk or posedge rst)
      begin
        if (rst)
          mem_q[i] <= {W{1'b0}};
        else if (ce && push && wr_q == i)
          mem_q[i] <= in_data;
      end
    end
  endgenerate

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      in_ready_q <= 1'b1;
      out_valid_q <= 1'b0;
      out_data_q <= {W{1'b0}};
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      // Ready is registered from the next count, so it drops just as the last entry fills
      in_ready_q <= cnt_d < FULL_CNT;
      if (push)
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      if (load)
      begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
        out_data_q <= mem_q[rd_q];
        out_valid_q <= 1'b1;
      end
      else if (out_ready)
        out_valid_q <= 1'b0;
    end
  end

  assign in_ready = in_ready_q;
  assign out_data = out_data_q;
  assign out_valid = out_valid_q;
endmodule // swdl_fifo

/* File: hw/swdl_link.v */
// Bit engine of the single-wire debug link, device end
`timescale 1ns/1ps
`include "swdl_defines.vh"

// Notes on behaviour
// - Memory and controller-register commands accepted at any time, program running or not.
// - Register, step and resume commands honoured only in the debug halt state.
// - Bits travel MSB first, nominally 16 debug-clock ticks per bit.
// - 512 ticks without host falling edge aborts the command, nothing changed.
// - Debug clock is bus clock or alternate source, per select bit.
// - Perceived start 0-1 tick after the fall; host bit sampled ten ticks later.
// - Driver stays off through every host-to-target bit.
// - Sending one: undriven until tick seven, then brief high pulse.
// - Sending zero: low 13 ticks from start, then brief high pulse.
// - Pseudo-open-drain pin with pullup; rises sped by short high pulses.
// - Pin high at reset means normal start; low means debug halt start.
// - Rate-probe request answered with a timed response pulse.
// - Link works any time, no reset needed, no user resources used.
// - Probe answer: await high, wait 16, low 128, one-tick pulse, release.
// - Each command opens with an 8-bit code; pauses are 16 ticks.
module swdl_link
#(
  parameter DATA_W = 8,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
)
(
  input wire clk,
  input wire rst,
  input wire ce,
  input wire debug_clock_select,
  input wire alt_clk_tick,
  input wire cpu_halted,
  input wire debug_wire_pin_in,
  output wire debug_wire_pin_out,
  output wire debug_wire_pin_oe,
  output wire debug_wire_pullup_en,
  output wire [DATA_W-1:0] rx_data,
  output wire rx_is_cmd,
  output wire rx_valid,
  input wire rx_ready,
  input wire [DATA_W-1:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  input wire cmd_done,
  output wire abort,
  output wire cmd_refused,
  output wire rx_overrun,
  output wire halt_at_start
);
  // ****************************************
  // Declarations
  // ****************************************
  wire tick;
  wire fifo_in_ready;
  wire [DATA_W:0] fifo_out;
  wire fall;
  wire busy;
  wire sync_seen;
  reg [2:0] st_q, st_d;
  reg [7:0] cnt_q, cnt_d;
  reg [7:0] low_q, low_d;
  reg [9:0] tmo_q, tmo_d;
  reg pin_prev_q;
  reg oe_q, oe_d;
  reg out_q, out_d;
  reg [DATA_W-1:0] rx_sh_q, rx_sh_d;
  reg [2:0] rx_bits_q, rx_bits_d;
  reg [DATA_W-1:0] tx_sh_q, tx_sh_d;
  reg [3:0] tx_left_q, tx_left_d;
  reg tx_ready_q, tx_ready_d;
  reg expect_cmd_q, expect_cmd_d;
  reg rxh_valid_q, rxh_valid_d;
  reg [DATA_W:0] rxh_q, rxh_d;
  reg abort_q, abort_d;
  reg refused_q, refused_d;
  reg overrun_q, overrun_d;
  reg strap_done_q;
  reg halt_start_q;
  reg pullup_q;
  reg [DATA_W-1:0] byte_w;

  // ****************************************
  // Debug clock and received-byte buffer
  // ****************************************
  swdl_tick u_tick
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .clk_sel(debug_clock_select),
    .alt_tick(alt_clk_tick),
    .tick(tick)
  );

  swdl_fifo
  #(
    .W(DATA_W + 1),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  )
  u_fifo
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_data(rxh_q),
    .in_valid(rxh_valid_q),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // ****************************************
  // Line observation
  // ****************************************
  // Fall seen on a tick gives the 0-1 tick start uncertainty
  assign fall = tick & pin_prev_q & ~debug_wire_pin_in;
  assign busy = ~expect_cmd_q | (rx_bits_q != 3'h0) | (tx_left_q != 4'h0);
  // A normal bit never stays low this long
  assign sync_seen = (low_q == `SWDL_SYNC_DET) & (st_q != `SWDL_ST_SWAIT);

  // ****************************************
  // Next-state logic
  // ****************************************
  always @*
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    low_d = low_q;
    tmo_d = tmo_q;
    oe_d = oe_q;
    out_d = out_q;
    rx_sh_d = rx_sh_q;
    rx_bits_d = rx_bits_q;
    tx_sh_d = tx_sh_q;
    tx_left_d = tx_left_q;
    tx_ready_d = tx_ready_q;
    expect_cmd_d = expect_cmd_q;
    rxh_valid_d = rxh_valid_q & ~fifo_in_ready;
    rxh_d = rxh_q;
    abort_d = 1'b0;
    refused_d = 1'b0;
    overrun_d = 1'b0;
    byte_w = {rx_sh_q[DATA_W-2:0], debug_wire_pin_in};

    if (cmd_done)
      expect_cmd_d = 1'b1;
    if (tx_valid && tx_ready_q)
    begin
      tx_sh_d = tx_data;
      tx_left_d = 4'h8;
      tx_ready_d = 1'b0;
    end

    if (tick)
    begin
      // Low time counts only while we are not driving
      if (!debug_wire_pin_in && !oe_q && low_q != `SWDL_SYNC_DET)
        low_d = low_q + 8'h01;
      else if (debug_wire_pin_in || oe_q)
        low_d = 8'h00;

      if (fall)
        tmo_d = 10'h000;
      else if (busy && tmo_q != `SWDL_TIMEOUT)
        tmo_d = tmo_q + 10'h001;

      case (st_q)
        `SWDL_ST_IDLE:
        begin
          if (fall)
          begin
            cnt_d = 8'h01;
            if (tx_left_q != 4'h0)
            begin
              st_d = `SWDL_ST_TBIT;
              oe_d = ~tx_sh_q[DATA_W-1];
              out_d = 1'b0;
            end
            else
              st_d = `SWDL_ST_HBIT;
          end
        end
        `SWDL_ST_HBIT:
        begin
          cnt_d = cnt_q + 8'h01;
          if (cnt_q == `SWDL_BIT_SAMPLE)
          begin
            // Bits arrive MSB first
            rx_sh_d = byte_w;
            rx_bits_d = rx_bits_q + 3'h1;
            st_d = `SWDL_ST_IDLE;
            if (rx_bits_q == `SWDL_BYTE_LAST)
            begin
              expect_cmd_d = 1'b0;
              if (expect_cmd_q && !byte_w[`SWDL_CMD_CLASS_BIT] && !cpu_halted)
                refused_d = 1'b1;
              else if (rxh_valid_q && !fifo_in_ready)
                overrun_d = 1'b1;
              else
              begin
                rxh_valid_d = 1'b1;
                rxh_d = {expect_cmd_q, byte_w};
              end
            end
          end
        end
        `SWDL_ST_TBIT:
        begin
          cnt_d = cnt_q + 8'h01;
          // Count equals ticks since the perceived start
          if (tx_sh_q[DATA_W-1])
          begin
            if (cnt_q == `SWDL_ONE_PULSE)
            begin
              oe_d = 1'b1;
              out_d = 1'b1;
            end
            else if (cnt_q == `SWDL_ONE_PULSE + 8'h01)
              oe_d = 1'b0;
          end
          else if (cnt_q == `SWDL_ZERO_LOW)
            out_d = 1'b1;
          else if (cnt_q == `SWDL_ZERO_LOW + 8'h01)
            oe_d = 1'b0;
          if ((tx_sh_q[DATA_W-1] && cnt_q == `SWDL_ONE_PULSE + 8'h01) ||
              (!tx_sh_q[DATA_W-1] && cnt_q == `SWDL_ZERO_LOW + 8'h01))
          begin
            st_d = `SWDL_ST_IDLE;
            out_d = 1'b0;
            tx_sh_d = {tx_sh_q[DATA_W-2:0], 1'b0};
            tx_left_d = tx_left_q - 4'h1;
            tx_ready_d = (tx_left_q == 4'h1);
          end
        end
        `SWDL_ST_SWAIT:
        begin
          if (debug_wire_pin_in)
          begin
            st_d = `SWDL_ST_SGAP;
            cnt_d = 8'h01;
          end
        end
        `SWDL_ST_SGAP:
        begin
          cnt_d = cnt_q + 8'h01;
          // Gap lets the host finish its own speedup pulse
          if (cnt_q == `SWDL_SYNC_GAP)
          begin
            st_d = `SWDL_ST_SLOW;
            cnt_d = 8'h01;
            oe_d = 1'b1;
            out_d = 1'b0;
          end
        end
        `SWDL_ST_SLOW:
        begin
          cnt_d = cnt_q + 8'h01;
          if (cnt_q == `SWDL_SYNC_LOW)
          begin
            st_d = `SWDL_ST_SPULSE;
            out_d = 1'b1;
          end
        end
        `SWDL_ST_SPULSE:
        begin
          st_d = `SWDL_ST_IDLE;
          oe_d = 1'b0;
          out_d = 1'b0;
        end
        default:
        begin
          st_d = `SWDL_ST_IDLE;
          oe_d = 1'b0;
        end
      endcase

      // Abort drops partial bytes and pending answers only
      if ((busy && tmo_q == `SWDL_TIMEOUT && !fall) || sync_seen)
      begin
        abort_d = 1'b1;
        st_d = sync_seen ? `SWDL_ST_SWAIT : `SWDL_ST_IDLE;
        oe_d = 1'b0;
        out_d = 1'b0;
        rx_bits_d = 3'h0;
        tx_left_d = 4'h0;
        tx_ready_d = 1'b1;
        expect_cmd_d = 1'b1;
        tmo_d = 10'h000;
        refused_d = 1'b0;
        rxh_valid_d = rxh_valid_q & ~fifo_in_ready;
      end
    end
  end

  // ****************************************
  // State registers
  // ****************************************
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= `SWDL_ST_IDLE;
      cnt_q <= 8'h00;
      low_q <= 8'h00;
      tmo_q <= 10'h000;
      pin_prev_q <= 1'b1;
      oe_q <= 1'b0;
      out_q <= 1'b0;
      rx_sh_q <= {DATA_W{1'b0}};
      rx_bits_q <= 3'h0;
      tx_sh_q <= {DATA_W{1'b0}};
      tx_left_q <= 4'h0;
      tx_ready_q <= 1'b1;
      expect_cmd_q <= 1'b1;
      rxh_valid_q <= 1'b0;
      rxh_q <= {(DATA_W+1){1'b0}};
      abort_q <= 1'b0;
      refused_q <= 1'b0;
      overrun_q <= 1'b0;
      strap_done_q <= 1'b0;
      halt_start_q <= 1'b0;
      pullup_q <= 1'b0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
      tmo_q <= tmo_d;
      // Strap edge seeds the detector, so a pin held low is no fall
      if (tick || !strap_done_q)
        pin_prev_q <= debug_wire_pin_in;
      oe_q <= oe_d;
      out_q <= out_d;
      rx_sh_q <= rx_sh_d;
      rx_bits_q <= rx_bits_d;
      tx_sh_q <= tx_sh_d;
      tx_left_q <= tx_left_d;
      tx_ready_q <= tx_ready_d;
      expect_cmd_q <= expect_cmd_d;
      rxh_valid_q <= rxh_valid_d;
      rxh_q <= rxh_d;
      abort_q <= abort_d;
      refused_q <= refused_d;
      overrun_q <= overrun_d;
      // Pullup on from the first enabled edge after reset, so an unconnected pin reads high
      pullup_q <= 1'b1;
      // Strap caught once, on the first enabled edge after release
      if (!strap_done_q)
      begin
        strap_done_q <= 1'b1;
        halt_start_q <= ~debug_wire_pin_in;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign debug_wire_pin_out = out_q;
  assign debug_wire_pin_oe = oe_q;
  assign debug_wire_pullup_en = pullup_q;
  assign rx_data = fifo_out[DATA_W-1:0];
  assign rx_is_cmd = fifo_out[DATA_W];
  assign tx_ready = tx_ready_q;
  assign abort = abort_q;
  assign cmd_refused = refused_q;
  assign rx_overrun = overrun_q;
  assign halt_at_start = halt_start_q;
endmodule // swdl_link

/* File: tb/swdl_link_monitor.sv */
// Checker of the debug link pin timing and stream handshakes
`timescale 1ns/1ps
module swdl_link_monitor
#(
  parameter DATA_W = 8
)
(
  input wire clk,
  input wire rst,
  input wire ce,
  input wire debug_clock_select,
  input wire cpu_halted,
  input wire debug_wire_pin_in,
  input wire debug_wire_pin_out,
  input wire debug_wire_pin_oe,
  input wire debug_wire_pullup_en,
  input wire [DATA_W-1:0] rx_data,
  input wire rx_valid,
  input wire rx_ready,
  input wire tx_valid,
  input wire tx_ready,
  input wire abort,
  input wire cmd_refused,
  input wire rx_overrun
);
  logic [9:0] lowc_q;
  logic [9:0] idle_q;
  logic [9:0] lo_q;
  // Idle count ignores falls made by our own driver
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lowc_q <= 10'h000;
      idle_q <= 10'h000;
      lo_q <= 10'h000;
    end
    else
    begin
      lowc_q <= (debug_wire_pin_oe && !debug_wire_pin_out) ? lowc_q + 10'h001 : 10'h000;
      if ($fell(debug_wire_pin_in) && !debug_wire_pin_oe)
        idle_q <= 10'h000;
      else if (idle_q != 10'h3FF)
        idle_q <= idle_q + 10'h001;
      if (!debug_wire_pin_in && !debug_wire_pin_oe && lo_q != 10'h3FF)
        lo_q <= lo_q + 10'h001;
      else if (debug_wire_pin_in || debug_wire_pin_oe)
        lo_q <= 10'h000;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_low_start;
    $rose(debug_wire_pin_oe) && !debug_wire_pin_out && !debug_clock_select;
  endsequence
  sequence s_speedup;
    debug_wire_pin_oe && debug_wire_pin_out && !debug_clock_select;
  endsequence
  a_low_hold: assert property (s_low_start |-> (debug_wire_pin_oe && !debug_wire_pin_out)[*8])
    else $error("Low drive ended early");
  a_low_length: assert property (s_speedup ##0 lowc_q != 0 |-> lowc_q == 13 || lowc_q == 128)
    else $error("Low drive length wrong before speedup");
  a_pulse_single: assert property (s_speedup |=> !debug_wire_pin_oe)
    else $error("Speedup pulse longer than one tick");
  a_pullup_on: assert property (ce |=> debug_wire_pullup_en)
    else $error("Pullup not enabled");
  a_abort_cause: assert property (abort && !debug_clock_select |-> lo_q >= 127 || idle_q >= 511)
    else $error("Abort without timeout or probe");
  a_refuse_run: assert property (cmd_refused |-> !cpu_halted)
    else $error("Command refused while halted");
  a_tx_take: assert property (tx_valid && tx_ready |=> !tx_ready)
    else $error("Transmit byte not taken");
  a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("Received byte not held");
  a_overrun_full: assert property (rx_overrun |-> rx_valid)
    else $error("Overrun with output stage empty");
endmodule // swdl_link_monitor

bind swdl_link swdl_link_monitor #(.DATA_W(DATA_W)) i_mon (.clk(clk), .rst(rst), .ce(ce),
  .debug_clock_select(debug_clock_select), .cpu_halted(cpu_halted),
  .debug_wire_pin_in(debug_wire_pin_in), .debug_wire_pin_out(debug_wire_pin_out),
  .debug_wire_pin_oe(debug_wire_pin_oe), .debug_wire_pullup_en(debug_wire_pullup_en),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .abort(abort), .cmd_refused(cmd_refused), .rx_overrun(rx_overrun));

/* File: tb/swdl_pod.sv */
// Host pod model driving the debug wire
`timescale 1ns/1ps
module swdl_pod
(
  input wire clk,
  input wire dev_oe,
  input wire dev_out,
  input wire pullup_en,
  output wire pin
);
  logic pod_oe = 1'h0;
  logic pod_out = 1'h1;
  logic tog_q = 1'h0;
  logic in_host = 1'h0;
  logic clash = 1'h0;
  always @(posedge clk)
  begin
    tog_q <= ~tog_q;
    if (in_host && dev_oe)
      clash <= 1'h1;
  end
  // Unpulled released line shows a moving level, not a stale one
  assign pin = dev_oe ? dev_out : pod_oe ? pod_out : pullup_en ? 1'h1 : tog_q;
  task automatic drive(input logic oe, input logic v, input int n);
  begin
    @(posedge clk);
    #1;
    pod_oe = oe;
    pod_out = v;
    repeat (n - 1) @(posedge clk);
  end
  endtask
  task automatic host_bit(input logic b);
  begin
    in_host = 1'h1;
    drive(1'h1, 1'h0, 4);
    drive(1'h1, b, 10);
    drive(1'h1, 1'h1, 1);
    in_host = 1'h0;
    drive(1'h0, 1'h1, 1);
  end
  endtask
  task automatic read_bit(output logic b);
  begin
    drive(1'h1, 1'h0, 2);
    drive(1'h0, 1'h1, 8);
    #1;
    b = pin;
    repeat (8) @(posedge clk);
  end
  endtask
  task automatic send_byte(input logic [7:0] v);
  begin
    for (int i = 7; i >= 0; i--)
      host_bit(v[i]);
  end
  endtask
  task automatic read_byte(output logic [7:0] v);
  begin
    for (int i = 7; i >= 0; i--)
      read_bit(v[i]);
  end
  endtask
  task automatic sync(output int n);
    int w;
  begin
    drive(1'h1, 1'h0, 130);
    drive(1'h1, 1'h1, 1);
    drive(1'h0, 1'h1, 1);
    n = 0;
    w = 0;
    while (pin !== 1'h0 && w < 300)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    while (pin === 1'h0 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  end
  endtask
endmodule // swdl_pod

/* File: tb/swdl_link_test.sv */
// Self-checking bench of the debug link bit engine
`timescale 1ns/1ps
module swdl_link_test;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cpu_halted = 1'h1;
  logic rx_ready = 1'h0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'h0;
  logic cmd_done = 1'h0;
  logic ce = 1'h1;
  logic clk_sel = 1'h0;
  logic alt_tick = 1'h0;
  logic ab_seen = 1'h0;
  logic ref_seen = 1'h0;
  logic ovr_seen = 1'h0;
  logic [7:0] d;
  logic c;
  wire pin, oe, dout, pu, rxv, rxc, txr, ab, refd, ovr, has;
  wire [7:0] rxd;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  swdl_link i_dut (.clk(clk), .rst(rst), .ce(ce), .debug_clock_select(clk_sel),
    .alt_clk_tick(alt_tick), .cpu_halted(cpu_halted), .debug_wire_pin_in(pin),
    .debug_wire_pin_out(dout), .debug_wire_pin_oe(oe), .debug_wire_pullup_en(pu),
    .rx_data(rxd), .rx_is_cmd(rxc), .rx_valid(rxv), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(txr), .cmd_done(cmd_done), .abort(ab),
    .cmd_refused(refd), .rx_overrun(ovr), .halt_at_start(has));
  swdl_pod i_pod (.clk(clk), .dev_oe(oe), .dev_out(dout), .pullup_en(pu), .pin(pin));
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (ab)
      ab_seen <= 1'h1;
    if (refd)
      ref_seen <= 1'h1;
    if (ovr)
      ovr_seen <= 1'h1;
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      finish_test;
    end
  end
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
  begin
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  end
  endtask
  task automatic finish_test;
  begin
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task automatic tick(input logic [1:0] which);
  begin
    if (which == 2'h0)
      cmd_done = 1'h1;
    else
      tx_valid = 1'h1;
    @(posedge clk);
    #1;
    cmd_done = 1'h0;
    tx_valid = 1'h0;
  end
  endtask
  task automatic get_rx;
    int w;
  begin
    w = 0;
    while (rxv !== 1'h1 && w < 200)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    d = rxd;
    c = rxc;
    rx_ready = 1'h1;
    @(posedge clk);
    #1;
    rx_ready = 1'h0;
  end
  endtask
  // Pod holds the level during reset, while the pullup is still off
  task automatic t_boot(input logic low);
  begin
    i_pod.pod_oe = 1'h1;
    i_pod.pod_out = ~low;
    rst = 1'h1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'h0;
    repeat (3) @(posedge clk);
    #1;
    check({8'h00, has}, {8'h00, low});
    check({8'h00, pu}, 9'h001);
    i_pod.pod_oe = 1'h0;
    repeat (4) @(posedge clk);
    #1;
  end
  endtask
  task automatic t_rx;
  begin
    i_pod.send_byte(8'hE4);
    get_rx;
    check({c, d}, 9'h1E4);
    i_pod.send_byte(8'h3C);
    get_rx;
    check({c, d}, 9'h03C);
    check({8'h00, i_pod.clash}, 9'h000);
  end
  endtask
  task automatic t_tx;
  begin
    tx_data = 8'hA5;
    tick(2'h1);
    check({8'h00, txr}, 9'h000);
    i_pod.read_byte(d);
    check({1'h0, d}, 9'h0A5);
    check({8'h00, txr}, 9'h001);
    tick(2'h0);
  end
  endtask
  task automatic t_refuse;
  begin
    cpu_halted = 1'h0;
    ref_seen = 1'h0;
    i_pod.send_byte(8'h10);
    check({8'h00, ref_seen}, 9'h001);
    check({8'h00, rxv}, 9'h000);
    tick(2'h0);
    i_pod.send_byte(8'hE0);
    get_rx;
    check({1'h0, d}, 9'h0E0);
    tick(2'h0);
    cpu_halted = 1'h1;
  end
  endtask
  task automatic t_timeout;
  begin
    ab_seen = 1'h0;
    i_pod.send_byte(8'hE1);
    get_rx;
    repeat (3) i_pod.host_bit(1'h1);
    repeat (480) @(posedge clk);
    check({8'h00, ab_seen}, 9'h000);
    repeat (100) @(posedge clk);
    check({8'h00, ab_seen}, 9'h001);
    i_pod.send_byte(8'hE8);
    get_rx;
    check({c, d}, 9'h1E8);
    tick(2'h0);
  end
  endtask
  task automatic t_sync;
  begin
    ab_seen = 1'h0;
    i_pod.sync(n);
    check(n[8:0], 9'h080);
    check({8'h00, ab_seen}, 9'h001);
    repeat (20) @(posedge clk);
    tick(2'h0);
  end
  endtask
  // Alternate source with no ticks must ignore the pin entirely
  task automatic t_clksel;
  begin
    clk_sel = 1'h1;
    i_pod.send_byte(8'hE4);
    repeat (8) @(posedge clk);
    #1;
    check({8'h00, rxv}, 9'h000);
    alt_tick = 1'h1;
    i_pod.send_byte(8'hE4);
    get_rx;
    check({c, d}, 9'h1E4);
    clk_sel = 1'h0;
    alt_tick = 1'h0;
    tick(2'h0);
  end
  endtask
  // Output stage, hold stage and 16 queued words fill before loss
  task automatic t_fill;
  begin
    ovr_seen = 1'h0;
    for (int i = 0; i < 20; i++)
      i_pod.send_byte(8'hC0 + i[7:0]);
    check({8'h00, ovr_seen}, 9'h001);
    ce = 1'h0;
    rx_ready = 1'h1;
    @(posedge clk);
    #1;
    ce = 1'h1;
    rx_ready = 1'h0;
    check({8'h00, rxv}, 9'h001);
    check({1'h0, rxd}, 9'h0C0);
    for (int i = 0; i < 18; i++)
    begin
      get_rx;
      check({1'h0, d}, {1'h0, 8'hC0 + i[7:0]});
    end
    repeat (8) @(posedge clk);
    check({8'h00, rxv}, 9'h000);
  end
  endtask
  initial
  begin
    t_boot(1'h1);
    t_boot(1'h0);
    t_rx;
    t_tx;
    t_refuse;
    t_timeout;
    t_sync;
    t_clksel;
    t_fill;
    finish_test;
  end
endmodule // swdl_link_test
